//--- pkg/ctl_pkg.sv
// constants for classification threshold learning, channels 1 and 2
// assumes a byte-wide command stream and byte-wide message sink on core_clk
package ctl_pkg;
  localparam int          AMP_W        = 16;
  localparam int          SUM_W        = 19;
  localparam int          NUM_CH       = 2;
  localparam int          RUN_LEN      = 5;
  localparam logic [7:0]  DEF_MULT     = 8'h0F;
  localparam logic [7:0]  CHR_CMD      = 8'h4B;
  localparam logic [7:0]  CHR_CH1      = 8'h31;
  localparam logic [7:0]  CHR_CH2      = 8'h32;
  localparam logic [7:0]  CHR_CR       = 8'h0D;
  localparam logic [7:0]  ACT_CANCEL   = 8'h30;
  localparam logic [7:0]  ACT_ARM      = 8'h31;
  localparam logic [7:0]  ACT_SHORT    = 8'h32;
  localparam logic [7:0]  ACT_RESTART  = 8'h33;
  localparam logic [7:0]  MSG_COUNT    = 8'h01;
  localparam logic [7:0]  MSG_DONE     = 8'h02;
  localparam logic [7:0]  TLG_CLASS    = 8'h01;
  localparam logic [7:0]  TLG_OTHER    = 8'h00;
  typedef enum logic [2:0] {
    CTL_P_IDLE, CTL_P_CH, CTL_P_ACT, CTL_P_CR
  } ctl_parse_type;
endpackage : ctl_pkg

//--- logic/ctl_chan.sv
// one channel: occupancy, peak capture, learning run, threshold store
// assumes amplitude and thresholds synchronous to core_clk
`timescale 1ns/10ps
module ctl_chan #(
  parameter int AMP_W = ctl_pkg::AMP_W
) (
  input  wire logic             core_clk,
  input  wire logic             resetn,
  input  wire logic             clk_en,
  input  wire logic             class_en,
  input  wire logic             chan_reset,
  input  wire logic             param_chg,
  input  wire logic [AMP_W-1:0] amplitude,
  input  wire logic [AMP_W-1:0] on_thresh,
  input  wire logic             cmd_arm,
  input  wire logic             cmd_cancel,
  input  wire logic             cmd_short,
  input  wire logic             cmd_restart,
  output logic                  detect_out,
  output logic                  class_out,
  output logic                  capture_ev,
  output logic [2:0]            capture_cnt,
  output logic                  done_ev,
  output logic                  neg_edge_ev,
  output logic [7:0]            class_byte,
  output logic [AMP_W-1:0]      class_thresh,
  output logic                  nv_we,
  output logic [AMP_W-1:0]      nv_data
);
  localparam int SW = ctl_pkg::SUM_W;
  logic [AMP_W-1:0] def_thr;
  logic             occ_ff, armed_ff, short_ff, seen_ff;
  logic [AMP_W-1:0] peak_ff, thr_ff;
  logic [SW-1:0]    sum_ff;
  logic [2:0]       cnt_ff;
  logic             end_veh, final_cap;
  logic [SW-1:0]    nxt_sum, mean_w;
  logic [SW+1:0]    red_w;
  logic [AMP_W+4:0] def_w;

  // default threshold, saturated
  assign def_w   = 21'(on_thresh) * 21'(ctl_pkg::DEF_MULT);
  assign def_thr = (def_w > 21'({AMP_W{1'b1}})) ? {AMP_W{1'b1}} : def_w[AMP_W-1:0];
  assign end_veh = occ_ff && (amplitude <= on_thresh);
  assign final_cap = armed_ff && end_veh && (short_ff || cnt_ff == 3'(ctl_pkg::RUN_LEN - 1));
  assign nxt_sum = sum_ff + SW'(peak_ff);
  // mean over captured samples, then three quarters
  assign mean_w  = nxt_sum / SW'(cnt_ff + 3'h1);
  assign red_w   = ({2'h0, mean_w} * 21'h3) >> 2;

  // occupancy and detection output, independent of learned threshold
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) occ_ff <= 1'b0;
    else if (clk_en) occ_ff <= (amplitude > on_thresh);
  end
  assign detect_out = occ_ff;

  // classification output, one assertion per passage
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) class_out <= 1'b0;
    else if (clk_en) begin
      if (amplitude <= on_thresh) class_out <= 1'b0;
      else if (class_en && amplitude > thr_ff) class_out <= 1'b1;
    end
  end

  // seen class this passage, telegram byte on negative edge
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      seen_ff <= 1'b0;
      neg_edge_ev <= 1'b0;
      class_byte <= ctl_pkg::TLG_OTHER;
    end else if (clk_en) begin
      neg_edge_ev <= end_veh;
      if (end_veh) begin
        class_byte <= (seen_ff || class_out) ? ctl_pkg::TLG_CLASS : ctl_pkg::TLG_OTHER;
        seen_ff <= 1'b0;
      end else if (class_out) seen_ff <= 1'b1;
    end
  end

  // peak of detuning during occupancy
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) peak_ff <= '0;
    else if (clk_en) begin
      if (!occ_ff) peak_ff <= (amplitude > on_thresh) ? amplitude : '0;
      else if (amplitude > peak_ff) peak_ff <= amplitude;
    end
  end

  // arming state, cancel only before the vehicle ends
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      armed_ff <= 1'b0;
      short_ff <= 1'b0;
    end else if (clk_en) begin
      if (chan_reset || param_chg || !class_en) begin
        armed_ff <= 1'b0;
        short_ff <= 1'b0;
      end else if (cmd_arm || cmd_restart || cmd_short) begin
        armed_ff <= 1'b1;
        short_ff <= cmd_short;
      end else if (cmd_cancel) begin
        armed_ff <= 1'b0;
        short_ff <= 1'b0;
      end else if (armed_ff && end_veh) begin
        armed_ff <= 1'b0;
        short_ff <= 1'b0;
      end
    end
  end

  // run accumulator and count
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sum_ff <= '0;
      cnt_ff <= '0;
    end else if (clk_en) begin
      if (chan_reset || param_chg || !class_en || cmd_restart || (final_cap && !cmd_cancel)) begin
        sum_ff <= '0;
        cnt_ff <= '0;
      end else if (armed_ff && end_veh && !cmd_cancel) begin
        sum_ff <= nxt_sum;
        cnt_ff <= cnt_ff + 3'h1;
      end
    end
  end

  // threshold register, store pulse, events
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      thr_ff <= '0;
      nv_we <= 1'b0;
      nv_data <= '0;
      done_ev <= 1'b0;
      capture_ev <= 1'b0;
      capture_cnt <= '0;
    end else if (clk_en) begin
      nv_we <= 1'b0;
      done_ev <= 1'b0;
      capture_ev <= 1'b0;
      if (chan_reset || param_chg || !class_en) thr_ff <= def_thr;
      else if (final_cap && !cmd_cancel) begin
        thr_ff <= red_w[AMP_W-1:0];
        nv_we <= 1'b1;
        nv_data <= red_w[AMP_W-1:0];
        done_ev <= 1'b1;
      end
      if (armed_ff && end_veh && !cmd_cancel && !chan_reset && !param_chg && class_en) begin
        capture_ev <= 1'b1;
        capture_cnt <= cnt_ff + 3'h1;
      end
    end
  end
  assign class_thresh = thr_ff;

  sequence s_cap;
    clk_en && final_cap && !cmd_cancel && !chan_reset && !param_chg && class_en;
  endsequence
  AST_DONE_STORE: assert property (@(posedge core_clk) disable iff (!resetn)
    s_cap |=> (done_ev && nv_we && nv_data == class_thresh))
    else $error("threshold not stored on final capture");
  AST_RESET_DEF: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && chan_reset) |=> (cnt_ff == 3'h0 && !armed_ff))
    else $error("channel reset did not restart learning");
  AST_CLASS_OFF: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && amplitude <= on_thresh) |=> !class_out)
    else $error("class output held below turn-on threshold");
  AST_CNT_MAX: assert property (@(posedge core_clk) disable iff (!resetn)
    cnt_ff < 3'(ctl_pkg::RUN_LEN))
    else $error("capture count beyond run length");
  AST_CAP_CNT: assert property (@(posedge core_clk) disable iff (!resetn)
    capture_ev |-> (capture_cnt >= 3'h1 && capture_cnt <= 3'(ctl_pkg::RUN_LEN)))
    else $error("capture count out of range");
  AST_DETECT: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en |=> detect_out == ($past(amplitude) > $past(on_thresh)))
    else $error("detect output not following turn-on threshold");
  AST_CANCEL: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && cmd_cancel && !cmd_arm && !cmd_short && !cmd_restart) |=> !armed_ff)
    else $error("cancel did not disarm");
  AST_PARAM: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && param_chg && class_en) |=> class_thresh == $past(def_thr))
    else $error("parameter change did not restore default");
endmodule : ctl_chan

//--- logic/ctl_top.sv
// top: command parser for the terminal stream, two learning channels, message out
// assumes cmd bytes from logic on core_clk; amplitudes on core_clk
`timescale 1ns/10ps
module ctl_top #(
  parameter int AMP_W = ctl_pkg::AMP_W
) (
  input  wire logic                core_clk,
  input  wire logic                resetn,
  input  wire logic                clk_en,
  input  wire logic                cmd_valid,
  input  wire logic [7:0]          cmd_byte,
  input  wire logic [1:0]          class_en,
  input  wire logic [1:0]          chan_reset,
  input  wire logic [1:0]          param_chg,
  input  wire logic [2*AMP_W-1:0]  amplitude,
  input  wire logic [2*AMP_W-1:0]  on_thresh,
  output logic [1:0]               detect_out,
  output logic [1:0]               class_out,
  output logic [1:0]               neg_edge_ev,
  output logic [15:0]              class_byte,
  output logic [2*AMP_W-1:0]       class_thresh,
  output logic [1:0]               nv_we,
  output logic [2*AMP_W-1:0]       nv_data,
  output logic                     msg_valid,
  output logic [7:0]               msg_kind,
  output logic                     msg_chan,
  output logic [2:0]               msg_count
);
  ctl_pkg::ctl_parse_type st_ff;
  logic       ch_ff;
  logic [7:0] act_ff;
  logic [1:0] arm, cancel, shrt, rst_cmd, cap_ev, done_ev;
  logic [5:0] cap_cnt;
  logic       go;
  logic [1:0] done_dly_ff;

  // parser for K, channel digit, action digit, CR
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= ctl_pkg::CTL_P_IDLE;
      ch_ff <= 1'b0;
      act_ff <= 8'h00;
    end else if (clk_en && cmd_valid) begin
      case (st_ff)
        ctl_pkg::CTL_P_IDLE: if (cmd_byte == ctl_pkg::CHR_CMD) st_ff <= ctl_pkg::CTL_P_CH;
        ctl_pkg::CTL_P_CH: begin
          ch_ff <= (cmd_byte == ctl_pkg::CHR_CH2);
          st_ff <= (cmd_byte == ctl_pkg::CHR_CH1 || cmd_byte == ctl_pkg::CHR_CH2) ?
                   ctl_pkg::CTL_P_ACT : ctl_pkg::CTL_P_IDLE;
        end
        ctl_pkg::CTL_P_ACT: begin
          act_ff <= cmd_byte;
          st_ff <= ctl_pkg::CTL_P_CR;
        end
        ctl_pkg::CTL_P_CR: st_ff <= ctl_pkg::CTL_P_IDLE;
        default: st_ff <= ctl_pkg::CTL_P_IDLE;
      endcase
    end
  end

  // decode on carriage return, one-cycle command pulses
  assign go = clk_en && cmd_valid && st_ff == ctl_pkg::CTL_P_CR && cmd_byte == ctl_pkg::CHR_CR;
  genvar g;
  generate
    for (g = 0; g < ctl_pkg::NUM_CH; g++) begin : g_ch
      assign arm[g]     = go && ch_ff == 1'(g) && act_ff == ctl_pkg::ACT_ARM;
      assign cancel[g]  = go && ch_ff == 1'(g) && act_ff == ctl_pkg::ACT_CANCEL;
      assign shrt[g]    = go && ch_ff == 1'(g) && act_ff == ctl_pkg::ACT_SHORT;
      assign rst_cmd[g] = go && ch_ff == 1'(g) && act_ff == ctl_pkg::ACT_RESTART;
      ctl_chan #(.AMP_W(AMP_W)) u_chan (
        .core_clk     (core_clk),
        .resetn       (resetn),
        .clk_en       (clk_en),
        .class_en     (class_en[g]),
        .chan_reset   (chan_reset[g]),
        .param_chg    (param_chg[g]),
        .amplitude    (amplitude[g*AMP_W +: AMP_W]),
        .on_thresh    (on_thresh[g*AMP_W +: AMP_W]),
        .cmd_arm      (arm[g]),
        .cmd_cancel   (cancel[g]),
        .cmd_short    (shrt[g]),
        .cmd_restart  (rst_cmd[g]),
        .detect_out   (detect_out[g]),
        .class_out    (class_out[g]),
        .capture_ev   (cap_ev[g]),
        .capture_cnt  (cap_cnt[g*3 +: 3]),
        .done_ev      (done_ev[g]),
        .neg_edge_ev  (neg_edge_ev[g]),
        .class_byte   (class_byte[g*8 +: 8]),
        .class_thresh (class_thresh[g*AMP_W +: AMP_W]),
        .nv_we        (nv_we[g]),
        .nv_data      (nv_data[g*AMP_W +: AMP_W])
      );
    end
  endgenerate

  // completion delayed one cycle so the final count message goes out first
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) done_dly_ff <= 2'h0;
    else if (clk_en) done_dly_ff <= done_ev;
  end

  // message to terminal: done wins, then count, channel 1 first
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      msg_valid <= 1'b0;
      msg_kind <= 8'h00;
      msg_chan <= 1'b0;
      msg_count <= 3'h0;
    end else if (clk_en) begin
      msg_valid <= |(done_dly_ff | cap_ev);
      if (done_dly_ff[0]) begin
        msg_kind <= ctl_pkg::MSG_DONE;
        msg_chan <= 1'b0;
      end else if (done_dly_ff[1]) begin
        msg_kind <= ctl_pkg::MSG_DONE;
        msg_chan <= 1'b1;
      end else if (cap_ev[0]) begin
        msg_kind <= ctl_pkg::MSG_COUNT;
        msg_chan <= 1'b0;
        msg_count <= cap_cnt[2:0];
      end else if (cap_ev[1]) begin
        msg_kind <= ctl_pkg::MSG_COUNT;
        msg_chan <= 1'b1;
        msg_count <= cap_cnt[5:3];
      end
    end
  end

  AST_ARM_DECODE: assert property (@(posedge core_clk) disable iff (!resetn)
    (go && act_ff == ctl_pkg::ACT_ARM) |-> |arm)
    else $error("arm command not decoded");
  AST_MSG_DONE: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && done_dly_ff[0]) |=> (msg_valid && msg_kind == ctl_pkg::MSG_DONE))
    else $error("completion message missing");
endmodule : ctl_top

//--- verif/ctl_term_model.sv
// service terminal model: sends command bytes, records device messages
// assumes core_clk shared with the design and clk_en held high
`timescale 1ns/10ps
module ctl_term_model (
  input  wire logic       core_clk,
  input  wire logic       msg_valid,
  input  wire logic [7:0] msg_kind,
  input  wire logic       msg_chan,
  input  wire logic [2:0] msg_count,
  output logic            cmd_valid,
  output logic [7:0]      cmd_byte
);
  int         cnt_msgs;
  int         done_msgs;
  logic       last_chan;
  logic [2:0] last_count;
  // =====================================================
  // idle line and empty logs at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_byte  = 8'h00;
    cnt_msgs  = 0;
    done_msgs = 0;
  end
  // letter, channel digit, action digit, carriage return, one per cycle
  task automatic send_cmd(input logic chan, input logic [7:0] act);
    logic [7:0] seq [4];
    seq = '{ctl_pkg::CHR_CMD, chan ? ctl_pkg::CHR_CH2 : ctl_pkg::CHR_CH1, act, ctl_pkg::CHR_CR};
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      #1;
      cmd_valid = 1'b1;
      cmd_byte  = seq[i];
    end
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b0;
    cmd_byte  = ~cmd_byte; // released byte never shows the last value
  endtask : send_cmd
  // log count and completion messages separately
  always @(posedge core_clk) begin
    if (msg_valid === 1'b1 && msg_kind === ctl_pkg::MSG_COUNT) begin
      cnt_msgs   = cnt_msgs + 1;
      last_chan  = msg_chan;
      last_count = msg_count;
    end
    if (msg_valid === 1'b1 && msg_kind === ctl_pkg::MSG_DONE) begin
      done_msgs = done_msgs + 1;
    end
  end
endmodule : ctl_term_model

//--- verif/test_classification_threshold_learning.sv
// self-checking bench for the two-channel threshold learning top
// assumes terminal model in ctl_term_model, clock 200 MHz, clk_en high except for one frozen cycle
`timescale 1ns/10ps
module test_classification_threshold_learning;
  localparam logic [15:0] ON  = 16'h0010;
  localparam logic [15:0] DEF = 16'(ON * ctl_pkg::DEF_MULT);
  logic        core_clk, resetn, cmd_valid, msg_valid, msg_chan, clk_en;
  logic [7:0]  cmd_byte, msg_kind;
  logic [1:0]  class_en, chan_reset, param_chg, detect_out, class_out, neg_edge_ev, nv_we;
  logic [31:0] amplitude, class_thresh, nv_data;
  logic [15:0] class_byte;
  logic [2:0]  msg_count;
  logic [31:0] seed;
  logic [15:0] nv_val [2];
  logic [15:0] tlg [2];
  logic [15:0] exp_thr [2];
  logic [1:0]  cls_seen, det_seen;
  int          nv_cnt [2];
  int          error_cnt, total_checks;
  ctl_top uut (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en), .cmd_valid(cmd_valid),
    .cmd_byte(cmd_byte), .class_en(class_en), .chan_reset(chan_reset), .param_chg(param_chg),
    .amplitude(amplitude), .on_thresh({ON, ON}), .detect_out(detect_out),
    .class_out(class_out), .neg_edge_ev(neg_edge_ev), .class_byte(class_byte),
    .class_thresh(class_thresh), .nv_we(nv_we), .nv_data(nv_data), .msg_valid(msg_valid),
    .msg_kind(msg_kind), .msg_chan(msg_chan), .msg_count(msg_count));
  ctl_term_model term (.core_clk(core_clk), .msg_valid(msg_valid), .msg_kind(msg_kind),
    .msg_chan(msg_chan), .msg_count(msg_count), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte));
  // =====================================================
  // helpers: random source, expectation, compare, verdict
  function automatic logic [15:0] rnd_peak();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return 16'h0100 + 16'(seed[9:0]);
  endfunction : rnd_peak
  function automatic logic [15:0] learn(input logic [18:0] s, input int n);
    return 16'((19'(s / n) * 3) / 4);
  endfunction : learn
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out
  // one vehicle with the given peak, two cycles per level, then empty loop
  task automatic veh(input int c, input logic [15:0] peak);
    logic [15:0] lvl [4];
    lvl = '{ON + 16'h0001, peak, ON + 16'h0002, 16'h0000};
    cls_seen[c] = 1'b0;
    det_seen[c] = 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      #1;
      amplitude[c*16 +: 16] = lvl[i];
      @(posedge core_clk);
    end
    repeat (4) @(posedge core_clk);
    #1;
    check("detect", 32'(det_seen[c]), 32'h1);
    check("class seen", 32'(cls_seen[c]), 32'(peak > exp_thr[c]));
    check("telegram", 32'(tlg[c]), 32'(peak > exp_thr[c]));
    check("outputs off", 32'({detect_out[c], class_out[c]}), 32'h0);
  endtask : veh
  // =====================================================
  // observe outputs sampled at each edge
  always @(posedge core_clk) begin
    for (int c = 0; c < 2; c++) begin
      cls_seen[c] = cls_seen[c] | (class_out[c] === 1'b1);
      det_seen[c] = det_seen[c] | (detect_out[c] === 1'b1);
      if (neg_edge_ev[c] === 1'b1) tlg[c] = 16'(class_byte[c*8 +: 8]);
      if (nv_we[c] === 1'b1) begin
        nv_cnt[c] = nv_cnt[c] + 1;
        nv_val[c] = nv_data[c*16 +: 16];
      end
    end
  end
  // =====================================================
  // clock, watchdog
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    #50000;
    error_cnt++;
    close_out();
  end
  // =====================================================
  // main sequence
  initial begin
    logic [18:0] sum;
    logic [15:0] p;
    int          n0;
    seed = 32'h557A;
    {resetn, class_en, chan_reset, param_chg, amplitude} = '0;
    clk_en = 1'b1;
    {cls_seen, det_seen, tlg[0], tlg[1]} = '0;
    nv_cnt = '{0, 0};
    error_cnt = 0;
    total_checks = 0;
    exp_thr = '{DEF, DEF};
    repeat (3) @(posedge core_clk);
    #1;
    resetn = 1'b1;
    class_en = 2'b11;
    chan_reset = 2'b11;
    @(posedge core_clk);
    #1;
    chan_reset = 2'b00;
    @(posedge core_clk);
    #1;
    check("default thr", class_thresh, {DEF, DEF});
    // full run of five on channel 1, armed before each vehicle
    sum = '0;
    for (int k = 1; k <= 5; k++) begin
      p = rnd_peak();
      sum = sum + 19'(p);
      term.send_cmd(1'b0, ctl_pkg::ACT_ARM);
      veh(0, p);
      check("count", {28'h0, term.last_chan, term.last_count}, 32'(k));
    end
    exp_thr[0] = learn(sum, 5);
    check("nv write", 32'(nv_cnt[0]), 32'h1);
    check("nv value", 32'(nv_val[0]), 32'(exp_thr[0]));
    check("done msg", 32'(term.done_msgs), 32'h1);
    check("learned thr", class_thresh, {DEF, exp_thr[0]});
    // weak vehicle: detection only, no class
    veh(0, ON + 16'h0005);
    // cancel before the vehicle on channel 2
    n0 = term.cnt_msgs;
    term.send_cmd(1'b1, ctl_pkg::ACT_ARM);
    term.send_cmd(1'b1, ctl_pkg::ACT_CANCEL);
    veh(1, rnd_peak());
    check("cancel", 32'(term.cnt_msgs), 32'(n0));
    // capture, restart discards it, three vehicles finished by short
    term.send_cmd(1'b1, ctl_pkg::ACT_ARM);
    veh(1, rnd_peak());
    term.send_cmd(1'b1, ctl_pkg::ACT_RESTART);
    sum = '0;
    for (int k = 1; k <= 3; k++) begin
      p = rnd_peak();
      sum = sum + 19'(p);
      if (k == 2) term.send_cmd(1'b1, ctl_pkg::ACT_ARM);
      if (k == 3) term.send_cmd(1'b1, ctl_pkg::ACT_SHORT);
      veh(1, p);
      check("restart count", {28'h0, term.last_chan, term.last_count}, 32'(k) + 32'h8);
      if (k < 3) check("nv kept", 32'(nv_cnt[1]), 32'h0);
    end
    exp_thr[1] = learn(sum, 3);
    check("short nv", 32'(nv_val[1]), 32'(exp_thr[1]));
    check("short done", 32'(term.done_msgs), 32'h2);
    // channel reset in mid-run restores the initial state
    term.send_cmd(1'b0, ctl_pkg::ACT_ARM);
    veh(0, rnd_peak());
    @(posedge core_clk);
    #1;
    chan_reset = 2'b01;
    @(posedge core_clk);
    #1;
    chan_reset = 2'b00;
    @(posedge core_clk);
    #1;
    exp_thr[0] = DEF;
    check("reset thr", class_thresh, {exp_thr[1], DEF});
    term.send_cmd(1'b0, ctl_pkg::ACT_RESTART);
    veh(0, rnd_peak());
    check("reset count", {28'h0, term.last_chan, term.last_count}, 32'h1);
    // clock enable low freezes state, parameter pulse ignored
    clk_en = 1'b0;
    param_chg = 2'b10;
    @(posedge core_clk);
    #1;
    param_chg = 2'b00;
    clk_en = 1'b1;
    @(posedge core_clk);
    #1;
    check("frozen thr", class_thresh, {exp_thr[1], DEF});
    // parameter change reverts the learned value
    param_chg = 2'b10;
    @(posedge core_clk);
    #1;
    param_chg = 2'b00;
    @(posedge core_clk);
    #1;
    check("param thr", class_thresh, {DEF, DEF});
    close_out();
  end
endmodule : test_classification_threshold_learning
